// >>> mfc_pkg.sv
// Constants, field layouts and carrier types for the mic front-end control
package mfc_pkg;

  // Timing: system clock and PDM clock bases
  localparam int unsigned SYS_CLK_HZ     = 40_000_000;
  localparam int unsigned PDM_BASE48_HZ  = 3_072_000;
  localparam int unsigned PDM_BASE44_HZ  = 2_822_400;
  localparam int unsigned PDM_HALF48_CYC = SYS_CLK_HZ / (2 * PDM_BASE48_HZ);
  localparam int unsigned PDM_HALF44_CYC = SYS_CLK_HZ / (2 * PDM_BASE44_HZ);
  localparam int unsigned PDM_WORD_BITS  = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BIAS = 8'h04;
  localparam logic [7:0] OFS_AMP  = 8'h08;
  localparam logic [7:0] OFS_PDM  = 8'h0c;
  localparam logic [7:0] OFS_FILT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;

  // Field positions
  localparam int unsigned CTRL_ACTIVE_BIT = 0;
  localparam int unsigned CTRL_FAM44_BIT  = 1;
  localparam int unsigned BIAS_LVL_LSB    = 0;
  localparam int unsigned BIAS_LP_BIT     = 3;
  localparam int unsigned BIAS_EN_BIT     = 4;
  localparam int unsigned AMP_SEL_LSB     = 0;
  localparam int unsigned AMP_EN_BIT      = 2;
  localparam int unsigned AMP_MUTE_BIT    = 3;
  localparam int unsigned AMP_GAIN_LSB    = 4;
  localparam int unsigned PDM_LEFT_BIT    = 0;
  localparam int unsigned PDM_RIGHT_BIT   = 1;
  localparam int unsigned PDM_RATE_BIT    = 2;
  localparam int unsigned PDM_SEL_BIT     = 3;
  localparam int unsigned PDM_PHASE_BIT   = 4;
  localparam int unsigned UNIT_B_SHIFT    = 8;
  localparam int unsigned STAT_OVR_BIT    = 8;
  localparam int unsigned DATA_VALID_BIT  = 31;

  // Writable masks and reset values
  localparam logic [31:0] MASK_CTRL = 32'h0000_0003;
  localparam logic [31:0] MASK_BIAS = 32'h0000_1f1f;
  localparam logic [31:0] MASK_AMP  = 32'h0000_7f7f;
  localparam logic [31:0] MASK_PDM  = 32'h0000_1f1f;
  localparam logic [31:0] MASK_FILT = 32'h0000_000f;
  localparam logic [31:0] LOCK_BIAS = 32'h0000_000f;
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_BIAS  = 32'h0000_0000;
  localparam logic [31:0] RST_AMP   = 32'h0000_0000;
  localparam logic [31:0] RST_PDM   = 32'h0000_0000;
  localparam logic [31:0] RST_FILT  = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic {PWR_STANDBY = 1'b0, PWR_ACTIVE = 1'b1} mfc_pwr_e;

  typedef struct packed {
    logic       on;
    logic       low_power;
    logic [2:0] level;
  } mfc_bias_s;

  typedef struct packed {
    logic [1:0] in_sel;
    logic       on;
    logic       mute;
    logic [2:0] gain;
  } mfc_amp_s;

endpackage

// >>> mfc_frontend.sv
// Mic front-end control: power mode, biases, amps, PDM ports, FIFO, AXI
// Contract
// - Standby disables all circuits; every control field keeps its value.
// - Active bit set enables reference voltage and oscillator; standby stops both.
// - Each bias has a 3-bit level, 1.6 V to 3.0 V in 0.2 V steps.
// - Bias level changes only while that bias is disabled.
// - Low-power bias mode fixes output at 1.2 V, level ignored.
// - Bias low-power bit changes only while disabled; each bias independent.
// - Bias enable bit turns its generator on; second bias identical.
// - Each amp selects differential, pseudo-differential or single-ended input.
// - Amp runs when enabled and is silenced when muted.
// - Amp 3-bit gain maps -6 dB to +36 dB in 6 dB steps.
// - PDM mode: positive pin drives clock, negative pin takes data.
// - Each PDM port has separate left and right enable bits.
// - Rate bit 0 gives full PDM clock, 1 gives half.
// - Data captured on both clock edges, two samples per period.
// - Select bit 0: rising edge left; 1 swaps the mapping.
// - Phase bit 0 samples at edges, 1 at midpoint between edges.
// - Converter active when its filter is on and its PDM channel off.
//
// Design decisions made here: the address map and register access over AXI4-Lite.

////////////////////////////////////////////////////////////////////////////////
module mfc_fifo
  import mfc_pkg::*;
#(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      wp_d;
  logic [AW:0]      rp_q;
  logic [AW:0]      rp_d;

  always_comb begin
    in_ready  = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
    out_valid = wp_q != rp_q;
    out_data  = mem[rp_q[AW-1:0]];
    wp_d      = wp_q + (AW+1)'(in_valid && in_ready);
    rp_d      = rp_q + (AW+1)'(out_valid && out_ready);
  end

  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mfc_frontend
  import mfc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output      logic       s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output      logic       s_axi_wready,
  output      logic [1:0] s_axi_bresp,
  output      logic       s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output      logic       s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0] s_axi_rresp,
  output      logic       s_axi_rvalid,
  input  wire logic       s_axi_rready,
  output      logic       ref_on,
  output      mfc_bias_s  bias_output_a,
  output      mfc_bias_s  bias_output_b,
  output      mfc_amp_s   amp_a,
  output      mfc_amp_s   amp_b,
  output      logic [3:0] conv_active,
  output      logic       pdm_clock_out_a,
  output      logic       input_a_pos_pin_oe,
  input  wire logic       input_a_neg_pin,
  output      logic       pdm_clock_out_b,
  output      logic       input_b_pos_pin_oe,
  input  wire logic       input_b_neg_pin
);
  localparam int unsigned FW = 17;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st,
                                         input logic [31:0] mask);
    logic [31:0] bm;
    bm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & mask;
    return (old & ~bm) | (wd & bm);
  endfunction

  function automatic logic [4:0] half_cyc(input logic fam44,
                                          input logic slow);
    logic [4:0] base;
    base = fam44 ? 5'(PDM_HALF44_CYC) : 5'(PDM_HALF48_CYC);
    return slow ? 5'(base << 1) : base;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave
  logic [31:0] ctrl_q, ctrl_d, bias_q, bias_d, amp_q, amp_d;
  logic [31:0] pdm_q, pdm_d, filt_q, filt_d, rdata_q, rdata_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        awh_q, awh_d, wh_q, wh_d, bvalid_q, bvalid_d;
  logic        rvalid_q, rvalid_d, arready_q, arready_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        ovr_q, ovr_d;
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d;
  logic        pop;
  logic        fifo_ovalid;
  logic [FW-1:0] fifo_odata;
  logic        fifo_ivalid, fifo_iready;
  logic [FW-1:0] fifo_idata;
  logic        ovr_set;
  logic        commit;
  logic [31:0] nb;
  logic [3:0]  conv_q, conv_d;

  always_comb begin
    ctrl_d = ctrl_q; bias_d = bias_q; amp_d = amp_q;
    pdm_d = pdm_q; filt_d = filt_q; rdata_d = rdata_q;
    awaddr_d = awaddr_q; wdata_d = wdata_q; wstrb_d = wstrb_q;
    awh_d = awh_q; wh_d = wh_q; bvalid_d = bvalid_q; bresp_d = bresp_q;
    rvalid_d = rvalid_q; arready_d = arready_q; rresp_d = rresp_q;
    ovr_d = ovr_q | ovr_set;
    pop = 1'b0;
    nb = '0;
    if (s_axi_awvalid && !awh_q && !bvalid_q) begin
      awh_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wh_q && !bvalid_q) begin
      wh_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    commit = awh_q && wh_q && !bvalid_q;
    if (commit) begin
      awh_d = 1'b0; wh_d = 1'b0; bvalid_d = 1'b1; bresp_d = RESP_OKAY;
      unique case (awaddr_q)
        OFS_CTRL: ctrl_d = wmerge(ctrl_q, wdata_q, wstrb_q, MASK_CTRL);
        OFS_BIAS: begin
          nb = wmerge(bias_q, wdata_q, wstrb_q, MASK_BIAS);
          for (int g = 0; g < 2; g++) begin
            if (bias_q[BIAS_EN_BIT + g * UNIT_B_SHIFT]) begin
              nb = (nb & ~(LOCK_BIAS << (g * UNIT_B_SHIFT)))
                 | (bias_q & (LOCK_BIAS << (g * UNIT_B_SHIFT)));
            end
          end
          bias_d = nb;
        end
        OFS_AMP:  amp_d  = wmerge(amp_q, wdata_q, wstrb_q, MASK_AMP);
        OFS_PDM:  pdm_d  = wmerge(pdm_q, wdata_q, wstrb_q, MASK_PDM);
        OFS_FILT: filt_d = wmerge(filt_q, wdata_q, wstrb_q, MASK_FILT);
        OFS_STAT: begin
          if (wstrb_q[1] && wdata_q[STAT_OVR_BIT]) begin
            ovr_d = ovr_set;
          end
        end
        default:  bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0; rvalid_d = 1'b1; rresp_d = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_d = ctrl_q;
        OFS_BIAS: rdata_d = bias_q;
        OFS_AMP:  rdata_d = amp_q;
        OFS_PDM:  rdata_d = pdm_q;
        OFS_FILT: rdata_d = filt_q;
        OFS_STAT: rdata_d = {22'h0, fifo_ovalid, ovr_q, conv_q, bias_q[12],
                             bias_q[BIAS_EN_BIT], ref_on, ctrl_q[0]};
        OFS_DATA: begin
          pop = fifo_ovalid;
          rdata_d = {fifo_ovalid, 14'h0, fifo_odata};
        end
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    // Ready flags registered so the bus outputs leave flops
    awrdy_d = !awh_d && !bvalid_d;
    wrdy_d = !wh_d && !bvalid_d;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= RST_CTRL; bias_q <= RST_BIAS; amp_q <= RST_AMP;
      pdm_q <= RST_PDM; filt_q <= RST_FILT; rdata_q <= '0;
      awaddr_q <= '0; wdata_q <= '0; wstrb_q <= '0;
      awh_q <= 1'b0; wh_q <= 1'b0; bvalid_q <= 1'b0; bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0; arready_q <= 1'b1; rresp_q <= RESP_OKAY;
      ovr_q <= 1'b0;
      awrdy_q <= 1'b1; wrdy_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d; bias_q <= bias_d; amp_q <= amp_d;
      pdm_q <= pdm_d; filt_q <= filt_d; rdata_q <= rdata_d;
      awaddr_q <= awaddr_d; wdata_q <= wdata_d; wstrb_q <= wstrb_d;
      awh_q <= awh_d; wh_q <= wh_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d;
      rvalid_q <= rvalid_d; arready_q <= arready_d; rresp_q <= rresp_d;
      ovr_q <= ovr_d;
      awrdy_q <= awrdy_d; wrdy_q <= wrdy_d;
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Power mode and analog controls
  mfc_pwr_e  pwr_q, pwr_d;
  logic      ref_q, ref_d;
  mfc_bias_s bias_o_q [2];
  mfc_bias_s bias_o_d [2];
  mfc_amp_s  amp_o_q [2];
  mfc_amp_s  amp_o_d [2];
  logic [1:0] pon_q, pon_d;

  always_comb begin
    pwr_d = ctrl_q[CTRL_ACTIVE_BIT] ? PWR_ACTIVE : PWR_STANDBY;
    unique case (pwr_q)
      PWR_STANDBY: ref_d = 1'b0;
      PWR_ACTIVE:  ref_d = 1'b1;
    endcase
    for (int g = 0; g < 2; g++) begin
      bias_o_d[g].on = ref_d && bias_q[BIAS_EN_BIT + g * 8];
      bias_o_d[g].low_power = bias_q[BIAS_LP_BIT + g * 8];
      bias_o_d[g].level = bias_q[BIAS_LP_BIT + g * 8]
                        ? 3'h0 : bias_q[g * 8 +: 3];
      amp_o_d[g].in_sel = amp_q[AMP_SEL_LSB + g * 8 +: 2];
      amp_o_d[g].on = ref_d && amp_q[AMP_EN_BIT + g * 8];
      amp_o_d[g].mute = amp_q[AMP_MUTE_BIT + g * 8];
      amp_o_d[g].gain = amp_q[AMP_GAIN_LSB + g * 8 +: 3];
      pon_d[g] = ref_d && (pdm_q[PDM_LEFT_BIT + g * 8]
                 || pdm_q[PDM_RIGHT_BIT + g * 8]);
    end
    for (int c = 0; c < 4; c++) begin
      conv_d[c] = ref_d && filt_q[c] && !pdm_q[(c / 2) * 8 + c % 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwr_q <= PWR_STANDBY; ref_q <= 1'b0; pon_q <= '0; conv_q <= '0;
      bias_o_q[0] <= '0; bias_o_q[1] <= '0;
      amp_o_q[0] <= '0; amp_o_q[1] <= '0;
    end else begin
      pwr_q <= pwr_d; ref_q <= ref_d; pon_q <= pon_d; conv_q <= conv_d;
      bias_o_q <= bias_o_d;
      amp_o_q <= amp_o_d;
    end
  end

  assign ref_on = ref_q;
  assign bias_output_a = bias_o_q[0];
  assign bias_output_b = bias_o_q[1];
  assign amp_a = amp_o_q[0];
  assign amp_b = amp_o_q[1];
  assign conv_active = conv_q;
  assign input_a_pos_pin_oe = pon_q[0];
  assign input_b_pos_pin_oe = pon_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // PDM ports: clock generation, capture and word assembly
  logic [4:0]  pcnt_q [2];
  logic [4:0]  pcnt_d [2];
  logic [2:0]  bitn_q [2];
  logic [2:0]  bitn_d [2];
  logic [7:0]  rsh_q [2];
  logic [7:0]  rsh_d [2];
  logic [7:0]  fsh_q [2];
  logic [7:0]  fsh_d [2];
  logic [15:0] pword_q [2];
  logic [15:0] pword_d [2];
  logic [1:0]  pclk_q, pclk_d, pend_q, pend_d, din_q, din_d;
  logic [1:0]  s1_q, s2_q, s3_q;
  logic [4:0]  half [2];
  logic [4:0]  spt;
  logic        samp, done, lsel;
  logic [7:0]  lw, rw;

  always_comb begin
    ovr_set = 1'b0;
    fifo_ivalid = |pend_q;
    fifo_idata = pend_q[0] ? {1'b0, pword_q[0]} : {1'b1, pword_q[1]};
    spt = '0; samp = 1'b0; done = 1'b0; lsel = 1'b0; lw = '0; rw = '0;
    for (int p = 0; p < 2; p++) begin
      half[p] = half_cyc(ctrl_q[CTRL_FAM44_BIT],
                         pdm_q[PDM_RATE_BIT + p * 8]);
      din_d[p] = (s2_q[p] == s3_q[p]) ? s3_q[p] : din_q[p];
      pcnt_d[p] = pcnt_q[p]; pclk_d[p] = pclk_q[p]; bitn_d[p] = bitn_q[p];
      rsh_d[p] = rsh_q[p]; fsh_d[p] = fsh_q[p]; pword_d[p] = pword_q[p];
      pend_d[p] = pend_q[p];
      if (fifo_iready && (p == 0 ? pend_q[0] : !pend_q[0] && pend_q[1])) begin
        pend_d[p] = 1'b0;
      end
      if (!pon_q[p]) begin
        pcnt_d[p] = '0; pclk_d[p] = 1'b0; bitn_d[p] = '0;
      end else begin
        if (pcnt_q[p] >= half[p] - 5'h1) begin
          pcnt_d[p] = '0;
          pclk_d[p] = !pclk_q[p];
        end else begin
          pcnt_d[p] = pcnt_q[p] + 5'h1;
        end
        spt = pdm_q[PDM_PHASE_BIT + p * 8] ? (half[p] >> 1) : 5'h0;
        samp = pcnt_q[p] == spt;
        if (samp && pclk_q[p]) begin
          rsh_d[p] = {rsh_q[p][6:0], din_q[p]};
        end
        if (samp && !pclk_q[p]) begin
          fsh_d[p] = {fsh_q[p][6:0], din_q[p]};
          bitn_d[p] = bitn_q[p] + 3'h1;
          done = bitn_q[p] == 3'(PDM_WORD_BITS - 1);
          lsel = pdm_q[PDM_SEL_BIT + p * 8];
          lw = lsel ? fsh_d[p] : rsh_q[p];
          rw = lsel ? rsh_q[p] : fsh_d[p];
          if (done) begin
            ovr_set = ovr_set | pend_d[p];
            pend_d[p] = 1'b1;
            pword_d[p] = {lw & {8{pdm_q[PDM_LEFT_BIT + p * 8]}},
                          rw & {8{pdm_q[PDM_RIGHT_BIT + p * 8]}}};
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    s1_q <= {input_b_neg_pin, input_a_neg_pin};
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (srst) begin
      pclk_q <= '0; pend_q <= '0; din_q <= '0;
      for (int p = 0; p < 2; p++) begin
        pcnt_q[p] <= '0; bitn_q[p] <= '0; rsh_q[p] <= '0;
        fsh_q[p] <= '0; pword_q[p] <= '0;
      end
    end else begin
      pclk_q <= pclk_d; pend_q <= pend_d; din_q <= din_d;
      pcnt_q <= pcnt_d; bitn_q <= bitn_d; rsh_q <= rsh_d;
      fsh_q <= fsh_d; pword_q <= pword_d;
    end
  end

  assign pdm_clock_out_a = pclk_q[0];
  assign pdm_clock_out_b = pclk_q[1];

  mfc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (fifo_ivalid),
    .in_ready  (fifo_iready),
    .in_data   (fifo_idata),
    .out_valid (fifo_ovalid),
    .out_ready (pop),
    .out_data  (fifo_odata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_standby_off;
    @(posedge sys_clk) disable iff (srst)
    !ctrl_q[CTRL_ACTIVE_BIT] |=> ##1 !ref_q && !bias_o_q[0].on && !pon_q[0];
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("circuit on in standby");

  property p_ref_on;
    @(posedge sys_clk) disable iff (srst)
    $rose(ctrl_q[CTRL_ACTIVE_BIT]) |=> ##1 ref_q;
  endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("reference not enabled two cycles after active");

  property p_level_lock;
    @(posedge sys_clk) disable iff (srst)
    bias_q[BIAS_EN_BIT] |=> bias_q[2:0] == $past(bias_q[2:0]);
  endproperty
  a_level_lock: assert property (p_level_lock)
    else $error("bias level changed while enabled");

  property p_lp_lock;
    @(posedge sys_clk) disable iff (srst)
    bias_q[12] |=> bias_q[11] == $past(bias_q[11]);
  endproperty
  a_lp_lock: assert property (p_lp_lock)
    else $error("bias low power changed while enabled");

  property p_level_out;
    @(posedge sys_clk) disable iff (srst)
    !bias_q[BIAS_LP_BIT] |=> bias_o_q[0].level == $past(bias_q[2:0]);
  endproperty
  a_level_out: assert property (p_level_out)
    else $error("bias level not passed to output");

  property p_lp_fixed;
    @(posedge sys_clk) disable iff (srst)
    bias_o_q[1].low_power |-> bias_o_q[1].level == 3'h0;
  endproperty
  a_lp_fixed: assert property (p_lp_fixed)
    else $error("level not ignored in low power");

  property p_bias_en;
    @(posedge sys_clk) disable iff (srst)
    pwr_q == PWR_ACTIVE && bias_q[12] |=> bias_o_q[1].on;
  endproperty
  a_bias_en: assert property (p_bias_en)
    else $error("enabled bias not on");

  property p_amp;
    @(posedge sys_clk) disable iff (srst)
    pwr_q == PWR_ACTIVE |=> amp_o_q[0].on == $past(amp_q[AMP_EN_BIT])
          && amp_o_q[0].gain == $past(amp_q[6:4]);
  endproperty
  a_amp: assert property (p_amp)
    else $error("amp output mismatch");

  property p_pdm_idle;
    @(posedge sys_clk) disable iff (srst)
    !pon_q[0] |=> !pclk_q[0] && !pdm_clock_out_a;
  endproperty
  a_pdm_idle: assert property (p_pdm_idle)
    else $error("pdm clock runs with port off");

  property p_clk_half;
    @(posedge sys_clk) disable iff (srst)
    pon_q[0] && pcnt_q[0] == half[0] - 5'h1 |=> pclk_q[0] != $past(pclk_q[0]);
  endproperty
  a_clk_half: assert property (p_clk_half)
    else $error("pdm clock did not toggle at half period");

  property p_conv;
    @(posedge sys_clk) disable iff (srst)
    pwr_q == PWR_ACTIVE && filt_q[1] && !pdm_q[PDM_RIGHT_BIT] |=> conv_q[1];
  endproperty
  a_conv: assert property (p_conv)
    else $error("converter not active");

  c_active: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(ref_q));
  c_push: cover property (@(posedge sys_clk) disable iff (srst)
    fifo_ivalid && fifo_iready);
  c_ovr: cover property (@(posedge sys_clk) disable iff (srst) $rose(ovr_q));
endmodule

// >>> mfc_pdm_mic.sv
// Stereo PDM microphone pair model for one data line
module mfc_pdm_mic (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic clk_in,
  input  wire logic oe,
  output      logic data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_q;
  // Released line toggles every cycle so no stale level survives
  always_ff @(posedge sys_clk) begin
    idle_q <= srst ? 1'b0 : ~idle_q;
  end
  // Rising-edge channel sends ones in the low half, falling-edge zeros
  assign data = oe ? ~clk_in : idle_q;
endmodule

// >>> mfc_frontend_tb.sv
// Self-checking bench for the mic front-end control block
module mfc_frontend_tb
  import mfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  aw_a, ar_a;
  logic [31:0] w_d, r_d, rd_v;
  logic [3:0]  conv;
  logic [1:0]  b_r, r_r, resp_v;
  logic        sys_clk, srst, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic        ref_on, pc_a, oe_a, d_a, pc_b, oe_b, d_b;
  mfc_bias_s   bias_a, bias_b;
  mfc_amp_s    amp_a, amp_b;
  int          mismatches, checks_done;

  mfc_frontend #(.FIFO_DEPTH(16)) dut (
    .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(b_r), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(r_d), .s_axi_rresp(r_r), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .ref_on(ref_on), .bias_output_a(bias_a),
    .bias_output_b(bias_b), .amp_a(amp_a), .amp_b(amp_b),
    .conv_active(conv), .pdm_clock_out_a(pc_a),
    .input_a_pos_pin_oe(oe_a), .input_a_neg_pin(d_a),
    .pdm_clock_out_b(pc_b), .input_b_pos_pin_oe(oe_b),
    .input_b_neg_pin(d_b));
  mfc_pdm_mic mic_a (.sys_clk(sys_clk), .srst(srst), .clk_in(pc_a),
    .oe(oe_a), .data(d_a));
  mfc_pdm_mic mic_b (.sys_clk(sys_clk), .srst(srst), .clk_in(pc_b),
    .oe(oe_b), .data(d_b));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    aw_a <= a; w_d <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      if (bv) begin
        done = 1'b1; resp_v = b_r; br <= 1'b0;
      end
    end
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    ar_a <= a; arv <= 1'b1; rr <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        done = 1'b1; rd_v = r_d; resp_v = r_r; rr <= 1'b0;
      end
    end
  endtask
  task automatic half(output int c);
    logic l;
    l = pc_a;
    while (pc_a === l) @(posedge sys_clk);
    l = pc_a; c = 0;
    while (pc_a === l) begin
      @(posedge sys_clk); c++;
    end
  endtask
  task automatic word(input logic [31:0] exp);
    int n;
    n = 0;
    rd_v = 32'hffff_ffff;
    while (rd_v[31] && n < 40) begin
      rd(OFS_DATA); n++;
    end
    repeat (700) @(posedge sys_clk);
    rd(OFS_DATA);
    rd(OFS_DATA);
    chk("pdm word", rd_v, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("ref reset", ref_on, 32'h0);
    rd(8'h3c);
    chk("unmapped rd", {rd_v[31:2], resp_v}, {30'h0, RESP_SLVERR});
    wr(8'h3c, 32'h1);
    chk("unmapped wr", resp_v, RESP_SLVERR);
  endtask
  task automatic t_power;
    wr(OFS_CTRL, 32'h1);
    chk("ref on", ref_on, 32'h1);
    wr(OFS_BIAS, 32'h0000_0015);
    chk("bias a", bias_a, {1'b1, 1'b0, 3'd5});
    wr(OFS_BIAS, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0);
    chk("ref off", ref_on, 32'h0);
    wr(OFS_BIAS, 32'h0000_0015);
    chk("bias standby", bias_a.on, 32'h0);
    rd(OFS_BIAS);
    chk("bias kept", rd_v, 32'h0000_0015);
    wr(OFS_CTRL, 32'h1);
  endtask
  task automatic t_bias;
    wr(OFS_BIAS, 32'h0000_001a);
    rd(OFS_BIAS);
    chk("bias locked", rd_v, 32'h0000_0015);
    wr(OFS_BIAS, 32'h0000_000f);
    wr(OFS_BIAS, 32'h0000_131f);
    chk("bias a lp", bias_a, {1'b1, 1'b1, 3'd0});
    chk("bias b", bias_b, {1'b1, 1'b0, 3'd3});
    wr(OFS_BIAS, 32'h0000_1b1f);
    rd(OFS_BIAS);
    chk("bias b locked", rd_v, 32'h0000_131f);
  endtask
  task automatic t_amp;
    logic [7:0] f;
    for (int g = 0; g < 8; g++) begin
      f = {1'b0, g[2:0], g[0], 1'b1, g[1:0]};
      wr(OFS_AMP, {16'h0, f ^ 8'h08, f});
      chk("amp a", amp_a, {g[1:0], 1'b1, g[0], g[2:0]});
      chk("amp b", amp_b, {g[1:0], 1'b1, ~g[0], g[2:0]});
    end
  endtask
  task automatic t_pdm;
    int c;
    wr(OFS_FILT, 32'hf);
    wr(OFS_PDM, 32'h1);
    chk("conv", conv, 32'he);
    chk("clk oe", oe_a, 32'h1);
    half(c);
    chk("half full", c, PDM_HALF48_CYC);
    word(32'h8000_ff00);
    wr(OFS_PDM, 32'h1b);
    word(32'h8000_00ff);
    wr(OFS_PDM, 32'h07);
    half(c);
    chk("half slow", c, 2 * PDM_HALF48_CYC);
    wr(OFS_CTRL, 32'h3);
    half(c);
    chk("half 44k", c, 2 * PDM_HALF44_CYC);
    wr(OFS_PDM, 32'h0a00);
    chk("clk oe b", oe_b, 32'h1);
    chk("clk oe a off", oe_a, 32'h0);
    word(32'h8001_00ff);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    mismatches = 0; checks_done = 0; srst = 1'b1;
    aw_a = 8'h0; ar_a = 8'h0; w_d = 32'h0;
    awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_power;
    t_bias;
    t_amp;
    t_pdm;
    close_out;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    close_out;
  end
endmodule
